// file: core/converter_config_pkg.sv
package converter_config_pkg;

  // ==========================================================
  // serial frame layout
  localparam int           INSTR_BITS    = 16;
  localparam int           DATA_BITS     = 8;
  localparam int           ADDR_W        = 13;
  localparam int           RW_BIT        = 15;
  localparam int           CNT_W         = 5;

  // ==========================================================
  // register offsets
  localparam logic [12:0]  ADDR_INPUT    = 13'h000f;
  localparam logic [12:0]  ADDR_TRIM     = 13'h0010;
  localparam logic [12:0]  ADDR_OUTFMT   = 13'h0014;
  localparam logic [12:0]  ADDR_PHASE    = 13'h0016;
  localparam logic [12:0]  ADDR_REFSCALE = 13'h0018;
  localparam logic [12:0]  ADDR_SIG_LOW  = 13'h0024;
  localparam logic [12:0]  ADDR_SIG_HIGH = 13'h0025;

  // ==========================================================
  // reset values and writable masks (open bits read zero)
  localparam logic [7:0]   RESET_BYTE    = 8'h00;
  localparam logic [7:0]   MASK_INPUT    = 8'h06;
  localparam logic [7:0]   MASK_TRIM     = 8'h0f;
  localparam logic [7:0]   MASK_OUTFMT   = 8'h1f;
  localparam logic [7:0]   MASK_PHASE    = 8'h80;
  localparam logic [7:0]   MASK_REFSCALE = 8'h1f;

  // ==========================================================
  // field positions
  localparam int           POS_DISCONNECT = 2;
  localparam int           POS_CM_ENABLE  = 1;
  localparam int           POS_OUT_ENABLE = 4;
  localparam int           POS_OUT_INVERT = 2;
  localparam int           POS_CLK_INVERT = 7;

  typedef enum logic [1:0] {
    FMT_OFFSET_BINARY = 2'b00,
    FMT_TWOS_COMP     = 2'b01,
    FMT_GRAY          = 2'b10,
    FMT_RESERVED      = 2'b11
  } data_format_t;

  typedef enum logic [0:0] {
    PH_INSTR = 1'b0,
    PH_DATA  = 1'b1
  } frame_phase_t;

  // ==========================================================
  // reference scale arithmetic, millivolts
  localparam logic [4:0]   REF_CODE_NOMINAL  = 5'h00;
  localparam logic [4:0]   REF_CODE_EXTERNAL = 5'h13;
  localparam logic [4:0]   REF_CODE_LOW_FIRST = 5'h14;
  localparam logic [10:0]  REF_NOMINAL_MV    = 11'h03e8;
  localparam logic [10:0]  REF_LOWEST_MV     = 11'h034c;
  localparam logic [10:0]  REF_STEP_MV       = 11'h000d;
  localparam logic [5:0]   REF_CODE_SPAN     = 6'h20;
  localparam logic [14:0]  FS_NUM            = 15'h000c;
  localparam logic [14:0]  FS_DEN            = 15'h000a;
  localparam logic [14:0]  FS_ROUND          = 15'h0005;

endpackage

// file: core/converter_config_registers.sv
`timescale 1ns/100ps
`default_nettype none

module converter_config_registers
  import converter_config_pkg::*;
(
  input  wire logic              ref_clk,           // 125 MHz clock
  input  wire logic              rstn,              // sync reset, low
  input  wire logic              spiSclk,           // serial clock pin
  input  wire logic              spiCsN,            // chip select, low
  input  wire logic              spiSdioIn,         // data pin input
  output logic                   spiSdioOut,        // data pin output
  output logic                   spiSdioOe,         // data pin enable
  input  wire logic              sigLoad,           // signature capture
  input  wire logic [15:0]       sigValue,          // signature word
  output logic                   analogDisconnect,  // input isolated
  output logic                   commonModeEnable,  // cm input on
  output logic signed [3:0]      offsetTrim,        // signed trim
  output logic signed [7:0]      offsetTrimExt,     // trim, extended
  output logic                   outputEnable,      // data outputs on
  output logic                   outputInvert,      // invert data
  output data_format_t           dataFormat,        // output coding
  output logic                   outputDataClockInv,// clock out invert
  output logic [4:0]             refScaleCode,      // reference code
  output logic                   refDriverLowLoad,  // external ref mode
  output logic [10:0]            refMillivolts,     // reference level
  output logic [10:0]            fullScaleMv        // input full scale
);

  // ==========================================================
  // decode helpers
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a == ADDR_INPUT)    || (a == ADDR_TRIM)    ||
               (a == ADDR_OUTFMT)   || (a == ADDR_PHASE)   ||
               (a == ADDR_REFSCALE) || (a == ADDR_SIG_LOW) ||
               (a == ADDR_SIG_HIGH);
  endfunction

  // reference millivolts: upper codes are negative steps
  function automatic logic [10:0] refLevel(input logic [4:0] c);
    logic [10:0] down;
    down = REF_STEP_MV * 11'(REF_CODE_SPAN - {1'b0, c});
    if (c >= REF_CODE_LOW_FIRST)
      refLevel = REF_NOMINAL_MV - down;
    else
      refLevel = REF_NOMINAL_MV + REF_STEP_MV * 11'(c);
  endfunction

  // ==========================================================
  // serial port
  logic [ADDR_W-1:0]  rdAddr;
  logic [7:0]         rdData;
  logic               wrStb;
  logic [ADDR_W-1:0]  wrAddr;
  logic [7:0]         wrData;

  spi_port_engine u_port (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .spiSclk    (spiSclk),
    .spiCsN     (spiCsN),
    .spiSdioIn  (spiSdioIn),
    .spiSdioOut (spiSdioOut),
    .spiSdioOe  (spiSdioOe),
    .rdAddr     (rdAddr),
    .rdData     (rdData),
    .wrStb      (wrStb),
    .wrAddr     (wrAddr),
    .wrData     (wrData)
  );

  // ==========================================================
  // register storage
  logic [7:0]  inputCtl_q;
  logic [7:0]  trim_q;
  logic [7:0]  outFmt_q;
  logic [7:0]  phase_q;
  logic [7:0]  refScale_q;
  logic [7:0]  sigLow_q;
  logic [7:0]  sigHigh_q;
  logic        wrOk;

  assign wrOk = wrStb & isMapped(wrAddr);

  // input path control
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      inputCtl_q <= RESET_BYTE;
    else if (wrOk && wrAddr == ADDR_INPUT)
      inputCtl_q <= wrData & MASK_INPUT;
  end

  // offset trim, four-bit two's complement
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      trim_q <= RESET_BYTE;
    else if (wrOk && wrAddr == ADDR_TRIM)
      trim_q <= wrData & MASK_TRIM;
  end

  // output mode and format
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      outFmt_q <= RESET_BYTE;
    else if (wrOk && wrAddr == ADDR_OUTFMT)
      outFmt_q <= wrData & MASK_OUTFMT;
  end

  // output clock phase
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      phase_q <= RESET_BYTE;
    else if (wrOk && wrAddr == ADDR_PHASE)
      phase_q <= wrData & MASK_PHASE;
  end

  // reference scale, upper bits held at zero
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      refScale_q <= RESET_BYTE;
    else if (wrOk && wrAddr == ADDR_REFSCALE)
      refScale_q <= wrData & MASK_REFSCALE;
  end

  // signature bytes follow the self-test engine only
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      sigLow_q  <= RESET_BYTE;
      sigHigh_q <= RESET_BYTE;
    end
    else if (sigLoad)
    begin
      sigLow_q  <= sigValue[7:0];
      sigHigh_q <= sigValue[15:8];
    end
  end

  // read mux, unmapped reads return zero
  always_comb
  begin
    rdData = RESET_BYTE;
    case (rdAddr)
      ADDR_INPUT:    rdData = inputCtl_q;
      ADDR_TRIM:     rdData = trim_q;
      ADDR_OUTFMT:   rdData = outFmt_q;
      ADDR_PHASE:    rdData = phase_q;
      ADDR_REFSCALE: rdData = refScale_q;
      ADDR_SIG_LOW:  rdData = sigLow_q;
      ADDR_SIG_HIGH: rdData = sigHigh_q;
      default:       rdData = RESET_BYTE;
    endcase
  end

  // ==========================================================
  // field outputs
  assign analogDisconnect   = inputCtl_q[POS_DISCONNECT];
  assign commonModeEnable   = inputCtl_q[POS_CM_ENABLE];
  assign offsetTrim         = $signed(trim_q[3:0]);
  assign offsetTrimExt      = 8'(signed'(trim_q[3:0]));
  assign outputEnable       = outFmt_q[POS_OUT_ENABLE];
  assign outputInvert       = outFmt_q[POS_OUT_INVERT];
  assign dataFormat         = data_format_t'(outFmt_q[1:0]);
  assign outputDataClockInv = phase_q[POS_CLK_INVERT];
  assign refScaleCode       = refScale_q[4:0];

  // reference level and full scale, registered
  logic [14:0] fsProduct;
  assign fsProduct = 15'(refLevel(refScale_q[4:0])) * FS_NUM;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      refMillivolts    <= REF_NOMINAL_MV;
      fullScaleMv      <= 11'((15'(REF_NOMINAL_MV) * FS_NUM) / FS_DEN);
      refDriverLowLoad <= 1'b0;
    end
    else
    begin
      refMillivolts    <= refLevel(refScale_q[4:0]);
      fullScaleMv      <= 11'((fsProduct + FS_ROUND) / FS_DEN);
      refDriverLowLoad <= (refScale_q[4:0] == REF_CODE_EXTERNAL);
    end
  end

  // ==========================================================
  // checks
  a_trim_signed: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    offsetTrimExt == {{4{trim_q[3]}}, trim_q[3:0]} && trim_q[7:4] == 4'h0)
    else $error("offset trim not a signed nibble");

  a_sig_low_load: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    sigLoad |=> sigLow_q == $past(sigValue[7:0]))
    else $error("signature low byte not captured");

  a_sig_readonly: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (wrStb && wrAddr == ADDR_SIG_LOW && !sigLoad) |=> $stable(sigLow_q))
    else $error("signature low byte changed by write");

  a_ref_reserved: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (wrStb && wrAddr == ADDR_REFSCALE) |=>
      refScale_q == {3'b000, $past(wrData[4:0])})
    else $error("reference field write wrong");

  a_full_scale: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $stable(refScale_q) |=> 15'(fullScaleMv) * FS_DEN + FS_ROUND
      >= 15'(refMillivolts) * FS_NUM &&
      15'(fullScaleMv) * FS_DEN <= 15'(refMillivolts) * FS_NUM + FS_ROUND)
    else $error("full scale not reference times 1.2");

  a_ref_lowload: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    refScale_q[4:0] == REF_CODE_EXTERNAL |=> refDriverLowLoad)
    else $error("external reference mode not flagged");

  a_ref_lowest: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    refScale_q[4:0] == REF_CODE_LOW_FIRST |=> refMillivolts == REF_LOWEST_MV)
    else $error("lowest reference code level wrong");

  a_ref_nominal: assert property (
    @(posedge ref_clk)
    (!rstn ##1 rstn) |-> refScale_q == RESET_BYTE &&
      refMillivolts == REF_NOMINAL_MV)
    else $error("reference not nominal after reset");

  a_out_enable: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (wrStb && wrAddr == ADDR_OUTFMT) |=>
      outputEnable == $past(wrData[POS_OUT_ENABLE]) &&
      dataFormat == $past(wrData[1:0]))
    else $error("output mode write not applied");

endmodule

`default_nettype wire

// file: core/spi_port_engine.sv
`timescale 1ns/100ps
`default_nettype none

module spi_port_engine
  import converter_config_pkg::*;
(
  input  wire logic              ref_clk,     // system clock
  input  wire logic              rstn,        // sync reset, low
  input  wire logic              spiSclk,     // serial clock pin
  input  wire logic              spiCsN,      // chip select, low
  input  wire logic              spiSdioIn,   // data pin, input side
  output logic                   spiSdioOut,  // data pin, output side
  output logic                   spiSdioOe,   // data pin enable
  output logic [ADDR_W-1:0]      rdAddr,      // current read address
  input  wire logic [7:0]        rdData,      // read byte at rdAddr
  output logic                   wrStb,       // one-cycle write pulse
  output logic [ADDR_W-1:0]      wrAddr,      // write address
  output logic [7:0]             wrData       // write byte
);

  // ==========================================================
  // frame state
  logic                sclkPrev_q;
  logic                rise;
  frame_phase_t        phase_q;
  logic [CNT_W-1:0]    bitCnt_q;
  logic [15:0]         shift_q;
  logic                readMode_q;
  logic [ADDR_W-1:0]   addr_q;
  logic                reload_q;
  logic [7:0]          txShift_q;

  assign rise   = spiSclk & ~sclkPrev_q & ~spiCsN;
  assign rdAddr = addr_q;

  // sclk edge reference
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      sclkPrev_q <= 1'b0;
    else
      sclkPrev_q <= spiSclk;
  end

  // instruction then data bytes, address walks down per byte
  always_ff @(posedge ref_clk)
  begin
    if (!rstn || spiCsN)
    begin
      phase_q    <= PH_INSTR;
      bitCnt_q   <= '0;
      shift_q    <= '0;
      readMode_q <= 1'b0;
      addr_q     <= '0;
      reload_q   <= 1'b0;
      wrStb      <= 1'b0;
      wrAddr     <= '0;
      wrData     <= RESET_BYTE;
    end
    else
    begin
      reload_q <= 1'b0;
      wrStb    <= 1'b0;
      if (rise)
      begin
        shift_q  <= {shift_q[14:0], spiSdioIn};
        bitCnt_q <= bitCnt_q + 1'b1;
        case (phase_q)
          PH_INSTR:
          begin
            if (bitCnt_q == CNT_W'(INSTR_BITS - 1))
            begin
              readMode_q <= shift_q[RW_BIT - 1];
              addr_q     <= {shift_q[ADDR_W-2:0], spiSdioIn};
              phase_q    <= PH_DATA;
              bitCnt_q   <= '0;
              reload_q   <= 1'b1;
            end
          end
          PH_DATA:
          begin
            if (bitCnt_q == CNT_W'(DATA_BITS - 1))
            begin
              wrStb    <= ~readMode_q;
              wrAddr   <= addr_q;
              wrData   <= {shift_q[6:0], spiSdioIn};
              addr_q   <= addr_q - 1'b1;
              bitCnt_q <= '0;
              reload_q <= 1'b1;
            end
          end
          default: phase_q <= PH_INSTR;
        endcase
      end
    end
  end

  // read byte loads after each address step, shifts on sclk rise
  always_ff @(posedge ref_clk)
  begin
    if (!rstn || spiCsN)
      txShift_q <= RESET_BYTE;
    else if (reload_q)
      txShift_q <= rdData;
    else if (rise && phase_q == PH_DATA)
      txShift_q <= {txShift_q[6:0], 1'b0};
  end

  assign spiSdioOut = txShift_q[7];
  assign spiSdioOe  = readMode_q & (phase_q == PH_DATA) & ~spiCsN;

endmodule

`default_nettype wire

// file: verification/converter_config_registers_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module converter_config_registers_tb_top
  import converter_config_pkg::*;
;
  localparam logic [12:0] ADRS [7] = '{ADDR_INPUT, ADDR_TRIM, ADDR_OUTFMT,
    ADDR_PHASE, ADDR_REFSCALE, ADDR_SIG_LOW, ADDR_SIG_HIGH};
  localparam logic [7:0]  MSKS [5] = '{MASK_INPUT, MASK_TRIM, MASK_OUTFMT,
    MASK_PHASE, MASK_REFSCALE};

  logic               ref_clk, rstn, spiSclk, spiCsN, spiSdioIn;
  logic               spiSdioOut, spiSdioOe, sigLoad, hostBit;
  logic [15:0]        sigValue;
  logic               analogDisconnect, commonModeEnable, outputEnable;
  logic               outputInvert, outputDataClockInv, refDriverLowLoad;
  logic signed [3:0]  offsetTrim;
  logic signed [7:0]  offsetTrimExt;
  data_format_t       dataFormat;
  logic [4:0]         refScaleCode;
  logic [10:0]        refMillivolts, fullScaleMv;
  int                 n_errors;
  int                 checks;

  // ==========================================================
  // clock and data line resolution
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  assign spiSdioIn = spiSdioOe ? spiSdioOut : hostBit;

  converter_config_registers dut_u (.ref_clk(ref_clk), .rstn(rstn),
    .spiSclk(spiSclk), .spiCsN(spiCsN), .spiSdioIn(spiSdioIn),
    .spiSdioOut(spiSdioOut), .spiSdioOe(spiSdioOe), .sigLoad(sigLoad),
    .sigValue(sigValue), .analogDisconnect(analogDisconnect),
    .commonModeEnable(commonModeEnable), .offsetTrim(offsetTrim),
    .offsetTrimExt(offsetTrimExt), .outputEnable(outputEnable),
    .outputInvert(outputInvert), .dataFormat(dataFormat),
    .outputDataClockInv(outputDataClockInv), .refScaleCode(refScaleCode),
    .refDriverLowLoad(refDriverLowLoad), .refMillivolts(refMillivolts),
    .fullScaleMv(fullScaleMv));

  spi_host_model host_u (.ref_clk(ref_clk), .sdioPin(spiSdioIn),
    .sclk(spiSclk), .csN(spiCsN), .hostBit(hostBit));

  // ==========================================================
  // expected reference level and full scale
  function automatic logic [10:0] ref_mv(input logic [4:0] c);
    if (c <= 5'h12)
      return 11'h03e8 + 11'h000d * {6'h00, c};
    return 11'h03e8 - 11'h000d * (11'h0020 - {6'h00, c});
  endfunction

  function automatic logic [10:0] fs_mv(input logic [10:0] mv);
    logic [14:0] t;
    t = {4'h0, mv} * 15'h000c + 15'h0005;
    return 11'(t / 15'h000a);
  endfunction

  // ==========================================================
  // compare, access and verdict tasks
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [15:0] x;
    host_u.halfCyc = 2 + ($urandom % 3);
    host_u.frame(1'b0, a, 1, {d, 8'h00}, x);
  endtask

  task automatic rc(input logic [12:0] a, input logic [7:0] e);
    logic [15:0] v;
    host_u.frame(1'b1, a, 1, 16'h0000, v);
    chk("readback", {8'h00, v[15:8]}, {8'h00, e});
  endtask

  // write, read back masked, then look at the field outputs
  task automatic apply(input int k, input logic [7:0] d);
    wr(ADRS[k], d);
    rc(ADRS[k], d & MSKS[k]);
    case (k)
      0:
      begin
        chk("disc", 16'(analogDisconnect), 16'(d[2]));
        chk("cm", 16'(commonModeEnable), 16'(d[1]));
      end
      1:
      begin
        chk("trim", {12'h000, offsetTrim}, {12'h000, d[3:0]});
        chk("trimExt", {8'h00, offsetTrimExt},
            {8'h00, {4{d[3]}}, d[3:0]});
      end
      2:
      begin
        chk("oe", 16'(outputEnable), 16'(d[4]));
        chk("inv", 16'(outputInvert), 16'(d[2]));
        chk("fmt", 16'(dataFormat), 16'(d[1:0]));
      end
      3:
        chk("clkInv", 16'(outputDataClockInv), 16'(d[7]));
      default:
      begin
        chk("code", 16'(refScaleCode), 16'(d[4:0]));
        chk("lowLoad", 16'(refDriverLowLoad), 16'(d[4:0] == 5'h13));
        if (d[4:0] != 5'h13)
        begin
          chk("refMv", 16'(refMillivolts), 16'(ref_mv(d[4:0])));
          chk("fsMv", 16'(fullScaleMv), 16'(fs_mv(ref_mv(d[4:0]))));
        end
      end
    endcase
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    logic [15:0] sv;
    rstn = 1'b0;
    sigLoad = 1'b0;
    sigValue = 16'h0000;
    n_errors = 0;
    checks = 0;
    void'($urandom(32'h6944));
    repeat (20) @(negedge ref_clk);
    rstn = 1'b1;
    // reset values of every register and of the reference level
    for (int k = 0; k < 7; k++)
      rc(ADRS[k], 8'h00);
    chk("refMv", 16'(refMillivolts), 16'h03e8);
    chk("fsMv", 16'(fullScaleMv), 16'h04b0);
    // random writes to all writable registers
    for (int k = 0; k < 5; k++)
      repeat (4) apply(k, 8'($urandom));
    // trim extremes and sign boundary
    apply(1, 8'hf7);
    apply(1, 8'h08);
    apply(1, 8'h0f);
    // every data format, other bits random
    for (int f = 0; f < 4; f++)
      apply(2, {6'($urandom), 2'(f)});
    // every reference code, reserved bits random
    for (int c = 0; c < 32; c++)
      apply(4, {3'($urandom), 5'(c)});
    // two-byte stream: address steps down after each byte
    host_u.frame(1'b0, ADDR_TRIM, 2, 16'hfaf6, sv);
    host_u.frame(1'b1, ADDR_TRIM, 2, 16'h0000, sv);
    chk("stream", sv, 16'h0a06);
    chk("trim", {12'h000, offsetTrim}, 16'h000a);
    // signature capture, read only against writes
    @(negedge ref_clk);
    sigValue = 16'($urandom);
    sigLoad = 1'b1;
    @(negedge ref_clk);
    sigLoad = 1'b0;
    rc(ADDR_SIG_LOW, sigValue[7:0]);
    rc(ADDR_SIG_HIGH, sigValue[15:8]);
    wr(ADDR_SIG_LOW, ~sigValue[7:0]);
    rc(ADDR_SIG_LOW, sigValue[7:0]);
    // unmapped place reads zero and ignores writes
    wr(13'h0030, 8'hff);
    rc(13'h0030, 8'h00);
    // second reset in mid-run restores nominal reference
    apply(4, 8'h05);
    @(negedge ref_clk);
    rstn = 1'b0;
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    rc(ADDR_REFSCALE, 8'h00);
    chk("refMv", 16'(refMillivolts), 16'h03e8);
    wrap_up();
  end
endmodule

`default_nettype wire

// file: verification/spi_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module spi_host_model
(
  input  wire logic ref_clk,  // system clock
  input  wire logic sdioPin,  // resolved data line
  output logic      sclk,     // serial clock
  output logic      csN,      // chip select, low
  output logic      hostBit   // host side of data line
);
  logic drvBit;
  logic hostOe;
  logic tgl;
  int   halfCyc;

  // ==========================================================
  // idle levels; serial clock stands low outside frames
  initial
  begin
    sclk = 1'b0;
    csN = 1'b1;
    hostOe = 1'b0;
    drvBit = 1'b0;
    tgl = 1'b0;
    halfCyc = 2;
  end

  // a released line shows a pattern changing every cycle
  always @(negedge ref_clk)
    tgl <= ~tgl;
  assign hostBit = hostOe ? drvBit : tgl;

  // ==========================================================
  // one frame: instruction word, then nb data bytes, msb first;
  // data is left-aligned in wd and rdat, the ignored instruction
  // bits carry noise, and the line is held until the sampling edge
  task automatic frame(input logic rd, input logic [12:0] adr,
                       input int nb, input logic [15:0] wd,
                       output logic [15:0] rdat);
    logic [31:0] w;
    w = {rd, 2'($urandom), adr, wd};
    rdat = 16'h0000;
    @(negedge ref_clk);
    csN = 1'b0;
    for (int i = 31; i >= 16 - 8 * nb; i--)
    begin
      hostOe = !(rd && i < 16);
      drvBit = w[i];
      repeat (halfCyc) @(negedge ref_clk);
      if (i < 16)
        rdat[i] = sdioPin;
      sclk = 1'b1;
      repeat (halfCyc) @(negedge ref_clk);
      sclk = 1'b0;
    end
    hostOe = 1'b0;
    repeat (2) @(negedge ref_clk);
    csN = 1'b1;
    repeat (2) @(negedge ref_clk);
  endtask
endmodule

`default_nettype wire
